//--- epd_decoder.sv
// Command decoder of the e-paper panel controller.
`timescale 1ns/1ps
// Function
// R1: Bytes with select low are commands; select high gives parameters or RAM data.
// R2: Sleep parameter 00 means normal operation, the reset default.
// R3: Sleep parameter 01 enters deep sleep one, 11 deep sleep two.
// R4: Entry command takes three low bits of entry sequence, reset value three.
// R5: Direction bits step X and Y independently, increment on one, both by default.
// R6: Axis bit zero steps X after writes, one steps Y.
// R7: Soft reset restores settings except sleep, keeps RAM, busy while running.
// R8: High-voltage detection runs busy, needs stages on, result in status read.
// R9: Supply threshold three bits; codes 011 to 111 valid, 100 default.
// R10: Supply detection starts when accepted, busy while running, result in status.
// R11: Temperature source byte, 48h external default, 80h internal.
// R12: Temperature write takes bits 11..4 then bits 3..0 in upper nibble.
// R13: Temperature read returns bits 11..4, then bits 3..0 padded with zeros.
// R14: Activation runs the stages chosen by the sequence option, busy throughout.
// R15: Host must not interrupt a running update while busy is high.
// R16: RAM option byte: upper nibble red, lower black/white, default zero.
// R17: Sequence option byte, default FFh; C7 and CF run full display updates.
// R18: Options 91, B1, 99, B9 load lookup table, optionally temperature first.
// R19: After 24h, data bytes fill black/white RAM with address advance.
// R20: After 26h, data bytes fill red RAM with address advance.
// R21: After 27h, reads fetch selected plane with address advance, first byte dummy.
// R22: Busy high during waveform output or sensor access; host then stays silent.
// R23: Parameters go in order to last command; extras and unknown codes ignored.
// R24: Settings take defaults on reset, and busy is low when idle.
module epd_decoder #(
  parameter int unsigned UPDATE_CYC = epd_pkg::UPDATE_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        cs_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        dc_i,
  input  wire logic        serial_width_select_i,
  input  wire logic        high_voltage_ok_i,
  input  wire logic        supply_level_ok_i,
  input  wire logic [11:0] temp_sensor_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             busy_o,
  output logic [1:0]       sleep_mode_o,
  output logic             clock_stage_on_o,
  output logic             analog_stage_on_o,
  output logic             display_drive_o,
  output logic             display_mode2_o,
  output logic [7:0]       ram_option_o,
  output logic [2:0]       supply_threshold_o,
  output logic [7:0]       temp_source_o
);

  typedef enum logic [2:0] {OP_IDLE, OP_SWRST, OP_HV, OP_SUP, OP_TS, OP_LUT, OP_DISP} epd_op_e;

  typedef struct packed {
    logic [1:0]  sy1;
    logic [1:0]  sy2;
    logic [1:0]  sleep;
    logic [2:0]  entry;
    logic [2:0]  thr;
    logic [7:0]  tsrc;
    logic [11:0] temp;
    logic [7:0]  ropt;
    logic [7:0]  uopt;
    logic        rsel;
    logic [7:0]  cmd;
    logic [1:0]  idx;
    logic [3:0]  xa;
    logic [8:0]  ya;
    logic        rd;
    logic [7:0]  tx;
    logic        tn;
    epd_op_e     op;
    logic [23:0] tmr;
    logic        clk_on;
    logic        ana_on;
    logic        hv_ok;
    logic        sup_ok;
    logic        busy;
    logic        disp;
    logic        mode2;
  } epd_top_s;

  localparam epd_top_s TOP_RST = '{
    sleep: epd_pkg::SLEEP_NORMAL, entry: epd_pkg::ENTRY_RST, thr: epd_pkg::THR_RST,
    tsrc: epd_pkg::TSRC_RST, temp: epd_pkg::TEMP_RST, ropt: epd_pkg::RAM_OPT_RST,
    uopt: epd_pkg::SEQ_OPT_RST, rsel: epd_pkg::RD_SEL_RST, op: OP_IDLE, default: '0};

  epd_top_s              q;
  epd_top_s              n;
  epd_pkg::epd_rx_s      rx;
  epd_pkg::epd_ram_req_s rq;
  logic [7:0]            ram_rdata;
  logic                  seq_end;
  logic                  step;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [12:0] step_addr(input logic [3:0] x, input logic [8:0] y,
                                            input logic [2:0] e);
    logic [3:0] nx;
    logic [8:0] ny;
    logic       xw;
    logic       yw;
    xw = e[epd_pkg::DIR_X_BIT] ? (x == epd_pkg::X_LAST) : (x == 4'h0);
    yw = e[epd_pkg::DIR_Y_BIT] ? (y == epd_pkg::Y_LAST) : (y == 9'h000);
    nx = e[epd_pkg::DIR_X_BIT] ? (xw ? 4'h0 : x + 4'h1) : (xw ? epd_pkg::X_LAST : x - 4'h1);
    ny = e[epd_pkg::DIR_Y_BIT] ? (yw ? 9'h000 : y + 9'h001) : (yw ? epd_pkg::Y_LAST : y - 9'h001);
    if (!e[epd_pkg::AXIS_BIT]) begin
      return {xw ? ny : y, nx};
    end
    return {ny, yw ? nx : x};
  endfunction : step_addr

  function automatic epd_op_e upd_after(input epd_op_e cur, input logic [7:0] opt);
    epd_op_e nx;
    nx = OP_IDLE;
    if (cur == OP_IDLE && opt[epd_pkg::SEQ_TS]) begin
      nx = OP_TS;
    end else if ((cur == OP_IDLE || cur == OP_TS) && opt[epd_pkg::SEQ_LUT]) begin
      nx = OP_LUT;
    end else if (cur != OP_DISP && opt[epd_pkg::SEQ_DISP]) begin
      nx = OP_DISP;
    end
    return nx;
  endfunction : upd_after

  function automatic logic [23:0] stage_cyc(input epd_op_e op);
    logic [23:0] c;
    c = 24'h000000;
    unique case (op)
      OP_SWRST:      c = 24'(epd_pkg::SWRST_CYC - 1);
      OP_HV, OP_SUP: c = 24'(epd_pkg::DETECT_CYC - 1);
      OP_TS:         c = 24'(epd_pkg::TS_CYC - 1);
      OP_LUT:        c = 24'(epd_pkg::LUT_CYC - 1);
      OP_DISP:       c = 24'(UPDATE_CYC - 1);
      OP_IDLE:       c = 24'h000000;
    endcase
    return c;
  endfunction : stage_cyc

  // ----------------------------------------
  // Decoder and sequencer
  // ----------------------------------------
  always_comb begin
    n = q;
    rq = '0;
    seq_end = 1'b0;
    step = 1'b0;
    n.sy1 = {high_voltage_ok_i, supply_level_ok_i};
    n.sy2 = q.sy1;
    rq.addr = {q.ya, q.xa};
    rq.plane = q.rd ? q.rsel : (q.cmd == epd_pkg::CMD_WR_RED);
    rq.wdata = rx.data;
    if (q.op != OP_IDLE) begin
      if (q.tmr != 24'h000000) begin
        n.tmr = q.tmr - 24'h000001;
      end else begin
        n.op = OP_IDLE;
        unique case (q.op)
          OP_HV: n.hv_ok = q.sy2[1] & q.clk_on & q.ana_on; // [R8]
          OP_SUP: n.sup_ok = q.sy2[0] & q.clk_on & q.ana_on; // [R10]
          OP_TS, OP_LUT, OP_DISP: begin
            if (q.op == OP_TS) begin
              n.temp = temp_sensor_i; // [R18]
            end
            n.op = upd_after(q.op, q.uopt); // [R14] [R18]
            seq_end = (n.op == OP_IDLE);
          end
          default: n.op = OP_IDLE;
        endcase
        n.tmr = stage_cyc(n.op);
      end
    end else if (rx.valid && q.sleep == epd_pkg::SLEEP_NORMAL) begin // [R3] [R22]
      if (!rx.dc) begin // [R1]
        n.cmd = rx.data;
        n.idx = 2'h0;
        n.rd = 1'b0;
        n.tn = 1'b0;
        case (rx.data) // [R23]
          epd_pkg::CMD_SWRST: begin // [R7]
            n.entry = TOP_RST.entry;
            n.thr = TOP_RST.thr;
            n.tsrc = TOP_RST.tsrc;
            n.temp = TOP_RST.temp;
            n.ropt = TOP_RST.ropt;
            n.uopt = TOP_RST.uopt;
            n.rsel = TOP_RST.rsel;
            n.xa = 4'h0;
            n.ya = 9'h000;
            n.op = OP_SWRST;
          end
          epd_pkg::CMD_HV_DETECT: n.op = OP_HV; // [R8]
          epd_pkg::CMD_TEMP_RD: begin
            n.rd = 1'b1;
            n.tx = q.temp[11:4]; // [R13]
          end
          epd_pkg::CMD_RD_RAM: begin
            n.rd = 1'b1;
            n.tx = epd_pkg::DUMMY_BYTE; // [R21]
          end
          epd_pkg::CMD_STATUS: begin
            n.rd = 1'b1;
            n.tx = 8'h00;
            n.tx[epd_pkg::STAT_HV] = q.hv_ok; // [R8]
            n.tx[epd_pkg::STAT_SUP] = q.sup_ok; // [R10]
          end
          epd_pkg::CMD_ACTIVATE: begin // [R14] [R17]
            n.clk_on = q.clk_on | q.uopt[epd_pkg::SEQ_CLK_ON];
            n.ana_on = q.ana_on | q.uopt[epd_pkg::SEQ_ANA_ON];
            n.mode2 = q.uopt[epd_pkg::SEQ_MODE2];
            n.op = upd_after(OP_IDLE, q.uopt);
            seq_end = (n.op == OP_IDLE);
          end
          default: n.op = OP_IDLE;
        endcase
        n.tmr = stage_cyc(n.op);
      end else if (q.rd) begin
        if (q.cmd == epd_pkg::CMD_RD_RAM) begin
          n.tx = ram_rdata; // [R21]
          step = 1'b1;
        end else if (q.cmd == epd_pkg::CMD_TEMP_RD && !q.tn) begin
          n.tx = {q.temp[3:0], 4'h0}; // [R13]
          n.tn = 1'b1;
        end else begin
          n.tx = 8'h00;
        end
      end else begin
        if (q.idx != 2'h3) begin
          n.idx = q.idx + 2'h1; // [R23]
        end
        case (q.cmd)
          epd_pkg::CMD_SLEEP: begin
            if (q.idx == 2'h0 && (rx.data[1:0] == epd_pkg::SLEEP_DEEP1 ||
                                  rx.data[1:0] == epd_pkg::SLEEP_DEEP2 ||
                                  rx.data[1:0] == epd_pkg::SLEEP_NORMAL)) begin
              n.sleep = rx.data[1:0]; // [R2] [R3]
            end
          end
          epd_pkg::CMD_ENTRY: if (q.idx == 2'h0) n.entry = rx.data[2:0]; // [R4]
          epd_pkg::CMD_SUP_DETECT: begin
            if (q.idx == 2'h0 && rx.data[2:0] >= epd_pkg::THR_MIN) begin
              n.thr = rx.data[2:0]; // [R9]
              n.op = OP_SUP; // [R10]
              n.tmr = stage_cyc(OP_SUP);
            end
          end
          epd_pkg::CMD_TEMP_SRC: if (q.idx == 2'h0) n.tsrc = rx.data; // [R11]
          epd_pkg::CMD_TEMP_WR: begin
            if (q.idx == 2'h0) begin
              n.temp[11:4] = rx.data; // [R12]
            end else if (q.idx == 2'h1) begin
              n.temp[3:0] = rx.data[7:4]; // [R12]
            end
          end
          epd_pkg::CMD_RAM_OPT: if (q.idx == 2'h0) n.ropt = rx.data; // [R16]
          epd_pkg::CMD_SEQ_OPT: if (q.idx == 2'h0) n.uopt = rx.data; // [R17]
          epd_pkg::CMD_RD_SEL: if (q.idx == 2'h0) n.rsel = rx.data[0];
          epd_pkg::CMD_WR_BW, epd_pkg::CMD_WR_RED: begin
            rq.we = 1'b1; // [R19] [R20]
            step = 1'b1;
          end
          default: n.idx = n.idx;
        endcase
      end
    end
    if (step) begin
      {n.ya, n.xa} = step_addr(q.xa, q.ya, q.entry); // [R5] [R6]
    end
    if (seq_end) begin
      if (q.uopt[epd_pkg::SEQ_ANA_OFF]) n.ana_on = 1'b0;
      if (q.uopt[epd_pkg::SEQ_OSC_OFF]) n.clk_on = 1'b0;
    end
    n.disp = (n.op == OP_DISP); // [R22]
    n.busy = (n.op != OP_IDLE); // [R7] [R22] [R24]
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      q <= TOP_RST; // [R2] [R24]
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Submodules and outputs
  // ----------------------------------------
  epd_link u_link (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .cs_n_i    (cs_n_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .dc_i      (dc_i),
    .width_i   (serial_width_select_i),
    .tx_en_i   (q.rd),
    .tx_byte_i (q.tx),
    .rx_o      (rx),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe_o)
  );

  epd_ram u_ram (
    .clk_sys_i (clk_sys_i),
    .req_i     (rq),
    .rdata_o   (ram_rdata)
  );

  assign busy_o = q.busy;
  assign sleep_mode_o = q.sleep;
  assign clock_stage_on_o = q.clk_on;
  assign analog_stage_on_o = q.ana_on;
  assign display_drive_o = q.disp;
  assign display_mode2_o = q.mode2;
  assign ram_option_o = q.ropt;
  assign supply_threshold_o = q.thr;
  assign temp_source_o = q.tsrc;

endmodule : epd_decoder

//--- epd_pkg.sv
// Shared constants and types of the e-paper command decoder.
package epd_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_SLEEP      = 8'h10;
  localparam logic [7:0] CMD_ENTRY      = 8'h11;
  localparam logic [7:0] CMD_SWRST      = 8'h12;
  localparam logic [7:0] CMD_HV_DETECT  = 8'h14;
  localparam logic [7:0] CMD_SUP_DETECT = 8'h15;
  localparam logic [7:0] CMD_TEMP_SRC   = 8'h18;
  localparam logic [7:0] CMD_TEMP_WR    = 8'h1A;
  localparam logic [7:0] CMD_TEMP_RD    = 8'h1B;
  localparam logic [7:0] CMD_ACTIVATE   = 8'h20;
  localparam logic [7:0] CMD_RAM_OPT    = 8'h21;
  localparam logic [7:0] CMD_SEQ_OPT    = 8'h22;
  localparam logic [7:0] CMD_WR_BW      = 8'h24;
  localparam logic [7:0] CMD_WR_RED     = 8'h26;
  localparam logic [7:0] CMD_RD_RAM     = 8'h27;
  localparam logic [7:0] CMD_STATUS     = 8'h2F;
  localparam logic [7:0] CMD_RD_SEL     = 8'h41;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [1:0]  SLEEP_NORMAL = 2'h0;
  localparam logic [1:0]  SLEEP_DEEP1  = 2'h1;
  localparam logic [1:0]  SLEEP_DEEP2  = 2'h3;
  localparam logic [2:0]  ENTRY_RST    = 3'h3;
  localparam logic [2:0]  THR_RST      = 3'h4;
  localparam logic [2:0]  THR_MIN      = 3'h3;
  localparam logic [7:0]  TSRC_RST     = 8'h48;
  localparam logic [11:0] TEMP_RST     = 12'h7FF;
  localparam logic [7:0]  RAM_OPT_RST  = 8'h00;
  localparam logic [7:0]  SEQ_OPT_RST  = 8'hFF;
  localparam logic        RD_SEL_RST   = 1'h0;
  localparam logic [7:0]  DUMMY_BYTE   = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DIR_X_BIT   = 0;
  localparam int DIR_Y_BIT   = 1;
  localparam int AXIS_BIT    = 2;
  localparam int SEQ_OSC_OFF = 0;
  localparam int SEQ_ANA_OFF = 1;
  localparam int SEQ_DISP    = 2;
  localparam int SEQ_MODE2   = 3;
  localparam int SEQ_LUT     = 4;
  localparam int SEQ_TS      = 5;
  localparam int SEQ_ANA_ON  = 6;
  localparam int SEQ_CLK_ON  = 7;
  localparam int STAT_SUP    = 0;
  localparam int STAT_HV     = 1;

  // ----------------------------------------
  // Geometry and link framing
  // ----------------------------------------
  localparam logic [3:0] X_LAST    = 4'hF;
  localparam logic [8:0] Y_LAST    = 9'h127;
  localparam int         RAM_DEPTH = 4736;
  localparam logic [3:0] LAST_4W   = 4'h7;
  localparam logic [3:0] LAST_3W   = 4'h8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned SWRST_TIME_NS  = 50000;
  localparam int unsigned DETECT_TIME_NS = 20000;
  localparam int unsigned TS_TIME_NS     = 20000;
  localparam int unsigned LUT_TIME_NS    = 10000;
  localparam int unsigned UPDATE_TIME_NS = 2000000;
  localparam int unsigned SWRST_CYC  = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DETECT_CYC = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TS_CYC     = (TS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LUT_CYC    = (LUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UPDATE_CYC = (UPDATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic cs_n;
    logic scl;
    logic sda;
    logic dc;
    logic wide;
  } epd_pin_s;

  typedef struct packed {
    logic       valid;
    logic       dc;
    logic [7:0] data;
  } epd_rx_s;

  typedef struct packed {
    logic        we;
    logic        plane;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } epd_ram_req_s;

endpackage : epd_pkg

//--- epd_link.sv
// Serial front end: pin synchronisers, byte receiver and read shifter.
`timescale 1ns/1ps
module epd_link (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic             cs_n_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  input  wire logic             dc_i,
  input  wire logic             width_i,
  input  wire logic             tx_en_i,
  input  wire logic [7:0]       tx_byte_i,
  output epd_pkg::epd_rx_s      rx_o,
  output logic                  sda_o,
  output logic                  sda_oe_o
);

  typedef struct packed {
    epd_pkg::epd_pin_s s1;
    epd_pkg::epd_pin_s s2;
    logic              scl_d;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic              dcb;
    logic              sdo;
    logic              oe;
    epd_pkg::epd_rx_s  rx;
  } epd_link_s;

  epd_link_s q;
  epd_link_s n;
  logic      rise;
  logic      fall;
  logic [3:0] off;
  logic [2:0] bi;

  // ----------------------------------------
  // Receive and shift
  // ----------------------------------------
  always_comb begin
    n = q;
    n.rx.valid = 1'b0;
    n.s1 = {cs_n_i, scl_i, sda_i, dc_i, width_i};
    n.s2 = q.s1;
    n.scl_d = q.s2.scl;
    rise = q.s2.scl & ~q.scl_d;
    fall = ~q.s2.scl & q.scl_d;
    off = {3'h0, q.s2.wide};
    bi = 3'(q.cnt - off);
    if (q.s2.cs_n) begin
      n.cnt = 4'h0;
    end else if (rise) begin
      n.sh = {q.sh[6:0], q.s2.sda};
      if (q.s2.wide && q.cnt == 4'h0) begin
        n.dcb = q.s2.sda; // [R1]
      end
      if (q.cnt == (q.s2.wide ? epd_pkg::LAST_3W : epd_pkg::LAST_4W)) begin
        n.cnt = 4'h0;
        n.rx.valid = 1'b1;
        n.rx.data = {q.sh[6:0], q.s2.sda};
        n.rx.dc = q.s2.wide ? q.dcb : q.s2.dc; // [R1]
      end else begin
        n.cnt = q.cnt + 4'h1;
      end
    end else if (fall && q.cnt >= off) begin
      n.sdo = tx_byte_i[3'h7 - bi];
    end
    n.oe = tx_en_i & ~q.s2.cs_n & (q.s2.wide ? (q.cnt != 4'h0 && q.dcb) : q.s2.dc);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rx_o = q.rx;
  assign sda_o = q.sdo;
  assign sda_oe_o = q.oe;

endmodule : epd_link

//--- epd_ram.sv
// Black/white and red display RAM planes with one write and one read port.
`timescale 1ns/1ps
module epd_ram (
  input  wire logic                  clk_sys_i,
  input  epd_pkg::epd_ram_req_s      req_i,
  output logic [7:0]                 rdata_o
);

  logic [7:0] bw_mem [epd_pkg::RAM_DEPTH];
  logic [7:0] red_mem [epd_pkg::RAM_DEPTH];
  logic [7:0] rdata_q;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (req_i.we && !req_i.plane) begin
      bw_mem[req_i.addr] <= req_i.wdata;
    end
    if (req_i.we && req_i.plane) begin
      red_mem[req_i.addr] <= req_i.wdata;
    end
    rdata_q <= req_i.plane ? red_mem[req_i.addr] : bw_mem[req_i.addr];
  end

  assign rdata_o = rdata_q;

endmodule : epd_ram

//--- epd_decoder_sva.sv
// Concurrent checks on the ports of the e-paper command decoder.
`timescale 1ns/1ps
module epd_decoder_sva #(
  parameter int unsigned UPDATE_CYC = 50
) (
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  input wire logic       busy_o,
  input wire logic [1:0] sleep_mode_o,
  input wire logic       clock_stage_on_o,
  input wire logic       analog_stage_on_o,
  input wire logic       display_drive_o,
  input wire logic [7:0] ram_option_o,
  input wire logic [2:0] supply_threshold_o,
  input wire logic [7:0] temp_source_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  logic [11:0] busy_cnt_q;
  logic [11:0] disp_cnt_q;
  // Counts the length of the current busy and display runs.
  always_ff @(posedge clk_sys_i) begin
    busy_cnt_q <= (busy_o && rstn_i) ? busy_cnt_q + 12'h001 : 12'h000;
    disp_cnt_q <= (display_drive_o && rstn_i) ? disp_cnt_q + 12'h001 : 12'h000;
  end
  property p_sleep_code;
    sleep_mode_o != 2'h2;
  endproperty
  property p_sleep_keep;
    sleep_mode_o != 2'h0 |=> sleep_mode_o == $past(sleep_mode_o);
  endproperty
  property p_sleep_quiet;
    sleep_mode_o != 2'h0 |-> !busy_o && !display_drive_o;
  endproperty
  property p_thr_legal;
    supply_threshold_o >= 3'h3;
  endproperty
  property p_disp_busy;
    display_drive_o |-> busy_o && clock_stage_on_o && analog_stage_on_o;
  endproperty
  property p_disp_len;
    $fell(display_drive_o) |-> disp_cnt_q == UPDATE_CYC;
  endproperty
  property p_busy_max;
    busy_cnt_q <= 12'h7D0;
  endproperty
  property p_disp_freeze;
    display_drive_o |=> $stable(ram_option_o) && $stable(temp_source_o)
      && $stable(supply_threshold_o);
  endproperty
  a_sleep_code: assert property (p_sleep_code) else $error("sleep code 10 seen");
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep left early");
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("busy in sleep");
  a_thr_legal: assert property (p_thr_legal) else $error("bad threshold");
  a_disp_busy: assert property (p_disp_busy) else $error("display not busy");
  a_disp_len: assert property (p_disp_len) else $error("display length");
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  a_disp_freeze: assert property (p_disp_freeze) else $error("setting moved");
  c_disp: cover property ($rose(display_drive_o));
  c_sleep: cover property (sleep_mode_o == 2'h3);
  c_swrst: cover property (busy_cnt_q == 12'h7D0);
endmodule : epd_decoder_sva

//--- epd_host_model.sv
// Host controller model driving the serial command link.
`timescale 1ns/1ps
module epd_host_model (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      cs_n_o,
  output logic      scl_o,
  output logic      sda_o,
  output logic      dc_o
);
  logic wide = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    scl_o  = 1'b0;
    sda_o  = 1'b0;
    dc_o   = 1'b0;
  end
  task automatic sel(input logic on);
    cs_n_o <= ~on;
    repeat (4) @(posedge clk_sys_i);
  endtask : sel
  // Sends one byte; select low marks a command, high a parameter.
  task automatic wr(input logic d, input logic [7:0] b);
    logic [8:0] w;
    w = {d, b};
    dc_o <= d;
    for (int i = wide ? 8 : 7; i >= 0; i--) begin
      sda_o <= w[i];
      repeat (4) @(posedge clk_sys_i);
      scl_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      scl_o <= 1'b0;
    end
    sda_o <= ~b[0];
    repeat (4) @(posedge clk_sys_i);
  endtask : wr
  // Reads one byte with slow half periods, sampling on the rising edge.
  task automatic rd(output logic [7:0] b);
    dc_o  <= 1'b1;
    sda_o <= wide ? 1'b1 : ~sda_o;
    if (wide) begin
      repeat (8) @(posedge clk_sys_i);
      scl_o <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      scl_o <= 1'b0;
    end
    for (int i = 7; i >= 0; i--) begin
      repeat (8) @(posedge clk_sys_i);
      scl_o <= 1'b1;
      b[i] = sda_i;
      repeat (8) @(posedge clk_sys_i);
      scl_o <= 1'b0;
    end
  endtask : rd
endmodule : epd_host_model

//--- epd_decoder_tb_top.sv
// Testbench of the e-paper command decoder.
`timescale 1ns/1ps
module epd_decoder_tb_top;
  logic        clk_sys_i, cs_n_i, scl_i, sda_i, dc_i, h_sda, sda_o, sda_oe_o, busy_o;
  logic        rstn_i = 1'b0;
  logic        serial_width_select_i = 1'b0;
  logic        high_voltage_ok_i = 1'b1;
  logic        supply_level_ok_i = 1'b1;
  logic [11:0] temp_sensor_i = 12'h123;
  logic        clock_stage_on_o, analog_stage_on_o, display_drive_o, display_mode2_o;
  logic [1:0]  sleep_mode_o;
  logic [2:0]  supply_threshold_o;
  logic [7:0]  ram_option_o, temp_source_o;
  int          err_total, total_checks, run_q, last_run;
  assign sda_i = sda_oe_o ? sda_o : h_sda;
  epd_decoder #(.UPDATE_CYC(50)) u_epd_decoder (.*);
  epd_host_model u_epd_host_model (.clk_sys_i(clk_sys_i), .sda_i(sda_i), .cs_n_o(cs_n_i),
    .scl_o(scl_i), .sda_o(h_sda), .dc_o(dc_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Measures the length of each busy run.
  always @(posedge clk_sys_i) begin
    if (busy_o === 1'b1) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      last_run <= run_q;
      run_q    <= 0;
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c, input int n, input logic [15:0] p);
    u_epd_host_model.sel(1'b1);
    u_epd_host_model.wr(1'b0, c);
    if (n > 0) u_epd_host_model.wr(1'b1, p[15:8]);
    if (n > 1) u_epd_host_model.wr(1'b1, p[7:0]);
    u_epd_host_model.sel(1'b0);
  endtask : cmd
  task automatic rdc(input logic [7:0] c, input logic [23:0] e, input int n);
    logic [7:0] b;
    u_epd_host_model.sel(1'b1);
    u_epd_host_model.wr(1'b0, c);
    for (int i = 0; i < n; i++) begin
      u_epd_host_model.rd(b);
      chk({4'h0, b}, {4'h0, e[23-8*i -: 8]});
    end
    u_epd_host_model.sel(1'b0);
  endtask : rdc
  task automatic wbusy(input logic [11:0] exp);
    last_run = 0;
    for (int i = 0; i < 3000 && last_run == 0; i++) @(posedge clk_sys_i);
    chk(last_run[11:0], exp);
  endtask : wbusy
  task automatic rst();
    rstn_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask : rst
  task automatic t_reset();
    rst();
    chk(12'(busy_o), 12'h000);
    chk(12'(sleep_mode_o), 12'h000);
    chk(12'(supply_threshold_o), 12'h004);
    chk(12'(temp_source_o), 12'h048);
    chk(12'(ram_option_o), 12'h000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_params();
    cmd(8'h18, 1, 16'h8000);
    cmd(8'h21, 2, 16'h8400);
    cmd(8'h5A, 1, 16'h1100);
    chk(12'(temp_source_o), 12'h080);
    chk(12'(ram_option_o), 12'h084);
    cmd(8'h1A, 2, 16'hABC0);
    rdc(8'h1B, 24'hABC000, 2);
    $display("t_params done");
  endtask : t_params
  task automatic t_detect();
    cmd(8'h15, 1, 16'h0200);
    repeat (20) @(posedge clk_sys_i);
    chk(12'(busy_o), 12'h000);
    chk(12'(supply_threshold_o), 12'h004);
    cmd(8'h15, 1, 16'h0700);
    wbusy(12'h320);
    chk(12'(supply_threshold_o), 12'h007);
    cmd(8'h14, 0, 16'h0000);
    wbusy(12'h320);
    rdc(8'h2F, 24'h000000, 1);
    $display("t_detect done");
  endtask : t_detect
  task automatic t_update();
    logic [7:0]  op [6] = '{8'hC7, 8'hCF, 8'h91, 8'h99, 8'hB1, 8'hB9};
    logic [11:0] len [6] = '{12'h032, 12'h032, 12'h190, 12'h190, 12'h4B0, 12'h4B0};
    for (int i = 0; i < 6; i++) begin
      cmd(8'h22, 1, {op[i], 8'h00});
      cmd(8'h20, 0, 16'h0000);
      wbusy(len[i]);
      chk(12'({clock_stage_on_o, analog_stage_on_o}), 12'h000);
      if (i < 2) chk(12'(display_mode2_o), 12'(i));
    end
    rdc(8'h1B, 24'h123000, 2);
    $display("t_update done");
  endtask : t_update
  task automatic t_swrst();
    cmd(8'h12, 0, 16'h0000);
    wbusy(12'h7D0);
    cmd(8'h24, 2, 16'hA55A);
    cmd(8'h26, 2, 16'h3CC3);
    cmd(8'h18, 1, 16'h8000);
    cmd(8'h12, 0, 16'h0000);
    wbusy(12'h7D0);
    chk(12'(temp_source_o), 12'h048);
    rdc(8'h27, 24'h00A55A, 3);
    cmd(8'h11, 1, 16'h0000);
    cmd(8'h41, 1, 16'h0100);
    rdc(8'h27, 24'h00C33C, 3);
    $display("t_swrst done");
  endtask : t_swrst
  task automatic t_sleep();
    cmd(8'h10, 1, 16'h0200);
    chk(12'(sleep_mode_o), 12'h000);
    cmd(8'h10, 1, 16'h0100);
    chk(12'(sleep_mode_o), 12'h001);
    cmd(8'h18, 1, 16'h8000);
    chk(12'(temp_source_o), 12'h048);
    rst();
    cmd(8'h10, 1, 16'h0300);
    chk(12'(sleep_mode_o), 12'h003);
    rst();
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_wide();
    serial_width_select_i <= 1'b1;
    u_epd_host_model.wide <= 1'b1;
    cmd(8'h21, 1, 16'h4800);
    chk(12'(ram_option_o), 12'h048);
    rdc(8'h1B, 24'h7FF000, 2);
    $display("t_wide done");
  endtask : t_wide
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    err_total++;
    test_done();
  end
  initial begin
    t_reset();
    t_params();
    t_detect();
    t_update();
    t_swrst();
    t_sleep();
    t_wide();
    test_done();
  end
endmodule : epd_decoder_tb_top
bind epd_decoder epd_decoder_sva #(.UPDATE_CYC(UPDATE_CYC)) u_epd_decoder_sva (.*);
